// ==== dpram_pkg.sv ====
// Shared constants for the synchronous dual-port RAM and its controller
package dpram_pkg;
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 8;
    localparam int DEPTH       = 65536;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_ONE  = 16'h0001;
    // Pipelined outputs need this many selected cycles to come back
    localparam logic [1:0] REACT_CYCLES = 2'h2;
    // Controller register offsets (byte addresses)
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_ADDR   = 4'h4;
    localparam logic [3:0] OFS_WDATA  = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // CTRL field positions
    localparam int CTRL_GO      = 0;
    localparam int CTRL_WRITE   = 1;
    localparam int CTRL_LOAD    = 2;
    localparam int CTRL_ADVANCE = 3;
    localparam int CTRL_CLEAR   = 4;
    localparam int CTRL_DESEL   = 5;
    localparam int CTRL_PIPE    = 6;
    localparam int CTRL_OE      = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0084;
    localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
    // Controller waits this many cycles before taking read data
    localparam logic [2:0] RD_WAIT_FT   = 3'h1;
    localparam logic [2:0] RD_WAIT_PIPE = 3'h2;
endpackage

// ==== dpram_if.sv ====
// Port link between the RAM port and its controller
`timescale 1ns/1ps
`default_nettype none
interface dpram_if;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rdata_oe_n;
    logic        chip_sel_low_n;
    logic        chip_sel_high;
    logic        rw;
    logic        out_en_n;
    logic        addr_strobe_n;
    logic        counter_advance_n;
    logic        counter_clear_n;
    logic        output_latency_sel;
    modport ram (
        input  addr, wdata, chip_sel_low_n, chip_sel_high, rw, out_en_n,
               addr_strobe_n, counter_advance_n, counter_clear_n,
               output_latency_sel,
        output rdata, rdata_oe_n
    );
    modport ctrl (
        output addr, wdata, chip_sel_low_n, chip_sel_high, rw, out_en_n,
               addr_strobe_n, counter_advance_n, counter_clear_n,
               output_latency_sel,
        input  rdata, rdata_oe_n
    );
endinterface
`default_nettype wire

// ==== ram_port.sv ====
// One synchronous port: input registers, address counter and output stage
`timescale 1ns/1ps
`default_nettype none
module ram_port (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        chip_sel_low_n,
    input  wire logic        chip_sel_high,
    input  wire logic        rw,
    input  wire logic        out_en_n,
    input  wire logic        addr_strobe_n,
    input  wire logic        counter_advance_n,
    input  wire logic        counter_clear_n,
    input  wire logic        output_latency_sel,
    input  wire logic [7:0]  mem_rdata,
    output logic [15:0]      acc_addr,
    output logic             wr_en,
    output logic [7:0]       wr_data,
    output logic [7:0]       rdata,
    output logic             rdata_oe_n
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        sel;
    logic        sel_reg;
    logic        rd_reg;
    logic        rd_pipe_reg;
    logic [1:0]  sel_run_reg;
    logic [7:0]  ft_data_reg;
    logic [7:0]  pipe_data_reg;
    logic        drive;

    assign sel = !chip_sel_low_n && chip_sel_high;

    // Counter next value: clear, load, advance or hold
    always_comb
    begin
        if (!counter_clear_n)
            cnt_next = dpram_pkg::ADDR_ZERO;                 // [RULE10] [RULE21]
        else if (!addr_strobe_n)
            cnt_next = addr;                                 // [RULE5] [RULE6]
        else if (!counter_advance_n)
            cnt_next = cnt_reg + dpram_pkg::ADDR_ONE;        // [RULE7]
        else
            cnt_next = cnt_reg;                              // [RULE8] [RULE9]
    end

    // Registered address counter, sampled at the rising edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= dpram_pkg::ADDR_ZERO;
        else
            cnt_reg <= cnt_next;                             // [RULE1]
    end

    // Access uses this cycle's new address, so no dead cycle on clear
    assign acc_addr = cnt_next;                              // [RULE6] [RULE10]
    // Write enable decoded from this cycle's controls; the array takes the write at the rising edge
    assign wr_en   = sel && !rw;                             // [RULE1] [RULE20]
    assign wr_data = wdata;

    // Control captured at the edge decides next cycle's output state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_reg <= 1'b0;
            rd_reg  <= 1'b0;
        end
        else
        begin
            sel_reg <= sel;                                  // [RULE11] [RULE19]
            rd_reg  <= sel && rw;                            // [RULE20]
        end
    end

    // Count selected cycles since a deselect; powered down when zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sel_run_reg <= 2'h0;
        else if (!sel)
            sel_run_reg <= 2'h0;                             // [RULE3]
        else if (sel_run_reg != dpram_pkg::REACT_CYCLES)
            sel_run_reg <= sel_run_reg + 2'h1;               // [RULE4]
    end

    // Read data: flow-through captured, and a second stage for pipelined
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ft_data_reg   <= 8'h00;
            pipe_data_reg <= 8'h00;
            rd_pipe_reg   <= 1'b0;
        end
        else
        begin
            if (sel && rw)
                ft_data_reg <= mem_rdata;
            pipe_data_reg <= ft_data_reg;
            rd_pipe_reg   <= rd_reg;
        end
    end

    // Output enable is asynchronous; pipelined needs two selected cycles
    always_comb
    begin
        if (output_latency_sel)                              // [RULE17]
            drive = rd_pipe_reg && sel_reg
                && (sel_run_reg == dpram_pkg::REACT_CYCLES); // [RULE4]
        else
            drive = rd_reg && sel_reg;                       // [RULE11]
    end

    assign rdata      = output_latency_sel ? pipe_data_reg : ft_data_reg;
    assign rdata_oe_n = !(drive && !out_en_n);               // [RULE2] [RULE19]
endmodule
`default_nettype wire

// ==== dpram_dev.sv ====
// Dual-port RAM device end: shared array and two port stages
`timescale 1ns/1ps
`default_nettype none
module dpram_dev (
    input  wire logic CLK_L,
    input  wire logic CLK_R,
    input  wire logic RST,
    dpram_if.ram      LEFT,
    dpram_if.ram      RIGHT
);
    // Contract
    // RULE1: inputs registered on rising clock edge
    // RULE2: output enable acts asynchronously
    // RULE3: deselect for one cycle powers down
    // RULE4: pipelined: two selected cycles reactivate outputs
    // RULE5: strobe low loads address every edge
    // RULE6: access address is external or counter
    // RULE7: advance low increments, new address accessed
    // RULE8: strobe and advance high hold address
    // RULE9: advance input stalls the counter
    // RULE10: counter clear has no dead cycle
    // RULE11: output state set by previous controls
    // RULE12: controller rewrites location after idle cycle
    // RULE13: reader waits maximum write-to-read delay
    // RULE14: long spacing: data valid after spacing
    // RULE15: depth banks share address, chip enables
    // RULE16: parallel devices form wider words
    // RULE17: latency select picks pipelined or flow-through
    // RULE18: latency select kept static
    // RULE19: deselect floats outputs after next edge
    // RULE20: read/write low writes, high reads
    // RULE21: clear low zeroes the counter
    logic [7:0]  mem [0:dpram_pkg::DEPTH-1];
    logic [15:0] acc_addr [2];
    logic        wr_en    [2];
    logic [7:0]  wr_data  [2];
    logic [7:0]  rd_word  [2];
    logic [7:0]  rdata    [2];
    logic        oe_n     [2];
    logic        clk_p    [2];

    assign clk_p[0] = CLK_L;
    assign clk_p[1] = CLK_R;

    // Each port reads the array at its access address
    assign rd_word[0] = mem[acc_addr[0]];
    assign rd_word[1] = mem[acc_addr[1]];

    ram_port u_left (
        .clk                (CLK_L),
        .rst                (RST),
        .addr               (LEFT.addr),
        .wdata              (LEFT.wdata),
        .chip_sel_low_n     (LEFT.chip_sel_low_n),
        .chip_sel_high      (LEFT.chip_sel_high),
        .rw                 (LEFT.rw),
        .out_en_n           (LEFT.out_en_n),
        .addr_strobe_n      (LEFT.addr_strobe_n),
        .counter_advance_n  (LEFT.counter_advance_n),
        .counter_clear_n    (LEFT.counter_clear_n),
        .output_latency_sel (LEFT.output_latency_sel),
        .mem_rdata          (rd_word[0]),
        .acc_addr           (acc_addr[0]),
        .wr_en              (wr_en[0]),
        .wr_data            (wr_data[0]),
        .rdata              (rdata[0]),
        .rdata_oe_n         (oe_n[0])
    );

    ram_port u_right (
        .clk                (CLK_R),
        .rst                (RST),
        .addr               (RIGHT.addr),
        .wdata              (RIGHT.wdata),
        .chip_sel_low_n     (RIGHT.chip_sel_low_n),
        .chip_sel_high      (RIGHT.chip_sel_high),
        .rw                 (RIGHT.rw),
        .out_en_n           (RIGHT.out_en_n),
        .addr_strobe_n      (RIGHT.addr_strobe_n),
        .counter_advance_n  (RIGHT.counter_advance_n),
        .counter_clear_n    (RIGHT.counter_clear_n),
        .output_latency_sel (RIGHT.output_latency_sel),
        .mem_rdata          (rd_word[1]),
        .acc_addr           (acc_addr[1]),
        .wr_en              (wr_en[1]),
        .wr_data            (wr_data[1]),
        .rdata              (rdata[1]),
        .rdata_oe_n         (oe_n[1])
    );

    // Power-up contents zeroed so reads before any write are defined
    initial
    begin
        for (int i = 0; i < dpram_pkg::DEPTH; i++)
            mem[i] = 8'h00;
    end

    // Array writes, one per port clock; same-address collisions undefined
    // Plain processes, since two clocked writers share the one array
    always @(posedge CLK_L)
    begin
        if (wr_en[0])
            mem[acc_addr[0]] <= wr_data[0];                  // [RULE20]
    end

    always @(posedge CLK_R)
    begin
        if (wr_en[1])
            mem[acc_addr[1]] <= wr_data[1];                  // [RULE20]
    end

    assign LEFT.rdata       = rdata[0];
    assign LEFT.rdata_oe_n  = oe_n[0];
    assign RIGHT.rdata      = rdata[1];
    assign RIGHT.rdata_oe_n = oe_n[1];
endmodule
`default_nettype wire

// ==== dpram_ctrl.sv ====
// Port controller: Avalon-MM register slave driving one RAM port
`timescale 1ns/1ps
`default_nettype none
module dpram_ctrl (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    dpram_if.ctrl            PORT
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYC  = 3'b010,
        ST_WAIT = 3'b100
    } state_e;

    state_e      state_reg;
    logic [31:0] ctrl_reg;
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  rdata_reg;
    logic        busy_reg;
    logic        rd_valid_reg;
    logic [2:0]  wait_reg;
    logic        go;
    logic        drive_cyc;

    assign go = AVS_WRITE && (AVS_ADDRESS == dpram_pkg::OFS_CTRL)
        && AVS_WRITEDATA[dpram_pkg::CTRL_GO];

    // Accesses while a cycle is in flight wait, so orders never overlap;
    // a read waits one cycle so registered data stand at the accepting edge
    assign AVS_WAITREQUEST = (busy_reg && (AVS_READ || AVS_WRITE))
        || (AVS_READ && !rd_valid_reg);

    // Register writes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_reg  <= dpram_pkg::CTRL_RESET;
            addr_reg  <= dpram_pkg::ADDR_ZERO;
            wdata_reg <= 8'h00;
        end
        else if (AVS_WRITE && !AVS_WAITREQUEST)
        begin
            case (AVS_ADDRESS)
                dpram_pkg::OFS_CTRL:  ctrl_reg  <= AVS_WRITEDATA;
                dpram_pkg::OFS_ADDR:  addr_reg  <= AVS_WRITEDATA[15:0];
                dpram_pkg::OFS_WDATA: wdata_reg <= AVS_WRITEDATA[7:0];
                default: ;
            endcase
        end
    end

    // Register reads, registered data, released on the following edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            AVS_READDATA <= dpram_pkg::UNMAPPED;
            rd_valid_reg <= 1'b0;
        end
        else if (AVS_READ && !busy_reg && !rd_valid_reg)
        begin
            rd_valid_reg <= 1'b1;
            case (AVS_ADDRESS)
                dpram_pkg::OFS_CTRL:   AVS_READDATA <= ctrl_reg;
                dpram_pkg::OFS_ADDR:   AVS_READDATA <= {16'h0000, addr_reg};
                dpram_pkg::OFS_WDATA:  AVS_READDATA <= {24'h000000, wdata_reg};
                dpram_pkg::OFS_STATUS:
                    AVS_READDATA <= {23'h000000, busy_reg, rdata_reg};
                default:               AVS_READDATA <= dpram_pkg::UNMAPPED;
            endcase
        end
        else
            rd_valid_reg <= 1'b0;
    end

    // One port cycle, then wait out the output latency for reads
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            wait_reg  <= 3'h0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (go && !busy_reg)
                    begin
                        state_reg <= ST_CYC;
                        busy_reg  <= 1'b1;
                    end
                ST_CYC:
                begin
                    state_reg <= ST_WAIT;
                    wait_reg  <= ctrl_reg[dpram_pkg::CTRL_PIPE] // [RULE14]
                        ? dpram_pkg::RD_WAIT_PIPE : dpram_pkg::RD_WAIT_FT;
                end
                ST_WAIT:
                    if (wait_reg == 3'h1)
                    begin
                        if (!ctrl_reg[dpram_pkg::CTRL_WRITE])
                            rdata_reg <= PORT.rdata;         // [RULE13]
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end
                    else
                        wait_reg <= wait_reg - 3'h1;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign drive_cyc = (state_reg == ST_CYC);

    // Port pins: strobes active only in the one access cycle
    assign PORT.addr           = addr_reg;                   // [RULE15]
    assign PORT.wdata          = wdata_reg;                  // [RULE16]
    assign PORT.chip_sel_low_n = ctrl_reg[dpram_pkg::CTRL_DESEL];
    assign PORT.chip_sel_high  = !ctrl_reg[dpram_pkg::CTRL_DESEL];
    assign PORT.rw = !(drive_cyc && ctrl_reg[dpram_pkg::CTRL_WRITE]);
    assign PORT.out_en_n = !ctrl_reg[dpram_pkg::CTRL_OE];
    assign PORT.addr_strobe_n =
        !(drive_cyc && ctrl_reg[dpram_pkg::CTRL_LOAD]);
    assign PORT.counter_advance_n =
        !(drive_cyc && ctrl_reg[dpram_pkg::CTRL_ADVANCE]);
    assign PORT.counter_clear_n =
        !(drive_cyc && ctrl_reg[dpram_pkg::CTRL_CLEAR]);
    // Static per software; change only while idle
    assign PORT.output_latency_sel = ctrl_reg[dpram_pkg::CTRL_PIPE]; // [RULE18]
endmodule
`default_nettype wire

// ==== dpram_link_assertions.sv ====
// Port-level checks on the link between one controller and the RAM port
`timescale 1ns/1ps
`default_nettype none
module dpram_link_assertions (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] rdata,
    input wire logic       rdata_oe_n,
    input wire logic       chip_sel_low_n,
    input wire logic       chip_sel_high,
    input wire logic       rw,
    input wire logic       out_en_n,
    input wire logic       addr_strobe_n,
    input wire logic       counter_advance_n,
    input wire logic       counter_clear_n,
    input wire logic       output_latency_sel
);
    logic sel;
    logic hold_rd;
    logic pipe;

    // Selected cycles and reads that neither load, advance nor clear
    assign sel = !chip_sel_low_n && chip_sel_high;
    assign hold_rd = sel && rw && addr_strobe_n && counter_advance_n
                     && counter_clear_n;
    assign pipe = output_latency_sel;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    chk_oe_gates_out: assert property (out_en_n |-> rdata_oe_n)
        else $error("data driven while output enable is off");
    chk_desel_float: assert property (!sel |=> rdata_oe_n)
        else $error("outputs still driven after deselect");
    chk_pipe_two_sel: assert property (pipe && !sel ##1 sel |=> rdata_oe_n)
        else $error("pipelined outputs back after one selected cycle");
    chk_ft_read_drive: assert property (!pipe && sel && rw ##1 !out_en_n
        |-> !rdata_oe_n)
        else $error("flow-through read not driven next cycle");
    chk_pipe_read_drive: assert property (pipe && sel && rw ##1 sel && rw
        ##1 !out_en_n |-> !rdata_oe_n)
        else $error("pipelined read not driven after two selects");
    chk_ft_reselect: assert property (!pipe && !sel ##1 sel && rw
        ##1 !out_en_n |-> !rdata_oe_n)
        else $error("flow-through read late after reselect");
    chk_ft_hold_data: assert property (!pipe && hold_rd [*2]
        |=> $stable(rdata))
        else $error("flow-through data moved while address held");
    chk_pipe_hold_data: assert property (pipe && hold_rd [*3]
        |=> $stable(rdata))
        else $error("pipelined data moved while address held");

    // Main situations the bench should reach
    cover property (pipe && hold_rd [*3]);
    cover property (pipe && !sel ##1 sel);
    cover property (out_en_n && sel && rw);
    cover property (!pipe && sel && !rw && !counter_advance_n);
endmodule
`default_nettype wire

// ==== sync_dual_port_ram_counter_ctrl_test.sv ====
// Self-checking bench: two controllers drive both ports of the RAM
`timescale 1ns/1ps
`default_nettype none
module sync_dual_port_ram_counter_ctrl_test;
    localparam logic [7:0] WR = 8'h01 << dpram_pkg::CTRL_WRITE;
    localparam logic [7:0] LD = 8'h01 << dpram_pkg::CTRL_LOAD;
    localparam logic [7:0] AD = 8'h01 << dpram_pkg::CTRL_ADVANCE;
    localparam logic [7:0] CL = 8'h01 << dpram_pkg::CTRL_CLEAR;
    localparam logic [7:0] DS = 8'h01 << dpram_pkg::CTRL_DESEL;
    localparam logic [7:0] PI = 8'h01 << dpram_pkg::CTRL_PIPE;
    localparam logic [7:0] OE = 8'h01 << dpram_pkg::CTRL_OE;
    logic        clk;
    logic        rst;
    logic [3:0]  av_a    [2];
    logic        av_rd   [2];
    logic        av_wr   [2];
    logic [31:0] av_wd   [2];
    logic [31:0] av_q    [2];
    logic        av_wait [2];
    logic        take;
    logic        take_p;
    logic [31:0] exp_q   [$];
    int          n_errors;
    int          num_checks;
    int          cyc = 0;
    logic [15:0] a_lo;
    logic [15:0] a_hi;
    logic [7:0]  d       [5];
    logic [7:0]  m;

    dpram_if lnk[2] ();
    dpram_dev i_dpram_dev (
        .CLK_L (clk),
        .CLK_R (clk),
        .RST   (rst),
        .LEFT  (lnk[0]),
        .RIGHT (lnk[1])
    );
    for (genvar g = 0; g < 2; g++)
    begin : g_side
        dpram_ctrl i_dpram_ctrl (
            .CLK             (clk),
            .RST             (rst),
            .AVS_ADDRESS     (av_a[g]),
            .AVS_READ        (av_rd[g]),
            .AVS_WRITE       (av_wr[g]),
            .AVS_WRITEDATA   (av_wd[g]),
            .AVS_READDATA    (av_q[g]),
            .AVS_WAITREQUEST (av_wait[g]),
            .PORT            (lnk[g])
        );
    end
    dpram_link_assertions i_link_chk (
        .CLK                (clk),
        .RST                (rst),
        .rdata              (lnk[0].rdata),
        .rdata_oe_n         (lnk[0].rdata_oe_n),
        .chip_sel_low_n     (lnk[0].chip_sel_low_n),
        .chip_sel_high      (lnk[0].chip_sel_high),
        .rw                 (lnk[0].rw),
        .out_en_n           (lnk[0].out_en_n),
        .addr_strobe_n      (lnk[0].addr_strobe_n),
        .counter_advance_n  (lnk[0].counter_advance_n),
        .counter_clear_n    (lnk[0].counter_clear_n),
        .output_latency_sel (lnk[0].output_latency_sel)
    );

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic close_out;
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One Avalon transfer; a read may leave a note for the monitor
    task automatic bus(input int p, input logic [3:0] a, input logic w,
                       input logic [31:0] v, input logic chk,
                       input logic [31:0] e);
        if (chk)
            exp_q.push_back(e);
        take <= chk;
        take_p <= p[0];
        av_a[p] <= a;
        av_rd[p] <= !w;
        av_wr[p] <= w;
        av_wd[p] <= v;
        @(posedge clk);
        while (av_wait[p] !== 1'h0)
            @(posedge clk);
        av_rd[p] <= 1'h0;
        av_wr[p] <= 1'h0;
        take <= 1'h0;
        // One idle edge, so no strobe is set twice in one time step
        @(posedge clk);
    endtask

    // One port cycle: address, data, command, then status
    task automatic op(input int p, input logic [7:0] b, input logic [15:0] a,
                      input logic [7:0] v, input logic chk,
                      input logic [7:0] e);
        bus(p, dpram_pkg::OFS_ADDR, 1'h1, {16'h0000, a}, 1'h0, 32'h0);
        bus(p, dpram_pkg::OFS_WDATA, 1'h1, {24'h0, v}, 1'h0, 32'h0);
        bus(p, dpram_pkg::OFS_CTRL, 1'h1, {24'h0, b | m | 8'h01}, 1'h0,
            32'h0);
        bus(p, dpram_pkg::OFS_STATUS, 1'h0, 32'h0, chk, {24'h0, e});
    endtask

    // Read data taken at the edge that accepts the read
    always @(posedge clk)
    begin
        if (take === 1'h1 && av_rd[take_p] === 1'h1
            && av_wait[take_p] === 1'h0)
            check(av_q[take_p], exp_q.pop_front());
    end

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out;
        end
    end

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        rst = 1'h1;
        take = 1'h0;
        take_p = 1'h0;
        n_errors = 0;
        num_checks = 0;
        m = 8'h00;
        for (int i = 0; i < 2; i++)
        begin
            av_a[i] = 4'h0;
            av_rd[i] = 1'h0;
            av_wr[i] = 1'h0;
            av_wd[i] = 32'h0;
        end
        void'($urandom(51));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        bus(0, dpram_pkg::OFS_CTRL, 1'h0, 32'h0, 1'h1, dpram_pkg::CTRL_RESET);
        bus(0, 4'h2, 1'h0, 32'h0, 1'h1, dpram_pkg::UNMAPPED);
        for (int k = 0; k < 2; k++)
        begin
            // Mode changes only while both ports are idle
            m = OE | (k != 0 ? PI : 8'h00);
            for (int p = 0; p < 2; p++)
                bus(p, dpram_pkg::OFS_CTRL, 1'h1, {24'h0, m}, 1'h0, 32'h0);
            foreach (d[i])
                d[i] = 8'($urandom);
            a_lo = {1'h0, 15'($urandom)};
            a_hi = {1'h1, 15'($urandom)};
            op(0, WR | LD, a_lo, d[0], 1'h0, 8'h00);
            op(0, WR | AD, a_lo, d[1], 1'h0, 8'h00);
            op(0, LD, a_lo, 8'h00, 1'h1, d[0]);
            op(0, AD, a_hi, 8'h00, 1'h1, d[1]);
            op(0, 8'h00, a_hi, 8'h00, 1'h1, d[1]);
            op(0, WR | CL, a_hi, d[2], 1'h0, 8'h00);
            op(0, 8'h00, a_lo, 8'h00, 1'h1, d[2]);
            op(1, WR | LD, a_hi, d[3], 1'h0, 8'h00);
            op(0, LD, a_hi, 8'h00, 1'h1, d[3]);
            op(1, LD, a_lo, 8'h00, 1'h1, d[0]);
            op(0, WR | LD | DS, a_lo, d[4], 1'h0, 8'h00);
            m = m & ~OE;
            op(0, LD, a_lo, 8'h00, 1'h1, d[0]);
            m = m | OE;
            op(0, WR | LD, a_lo, d[0], 1'h0, 8'h00);
            op(0, LD, a_lo, 8'h00, 1'h1, d[0]);
        end
        repeat (4) @(posedge clk);
        close_out;
    end
endmodule
`default_nettype wire
